// file: core/axis_pwm_pkg.sv
`default_nettype none
package axis_pwm_pkg;
   localparam int unsigned CLK_HZ          = 40000000;
   localparam int unsigned MS_PER_S        = 1000;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / MS_PER_S;
   localparam int unsigned TICK_W          = 16;
   localparam logic [15:0] PERIOD_MS_MIN   = 16'h0001;
   localparam logic [15:0] PERIOD_MS_MAX   = 16'h4e20;
   localparam logic [15:0] DUTY_PCT_MIN    = 16'h0001;
   localparam logic [15:0] DUTY_PCT_MAX    = 16'h0064;
   localparam logic        AXIS_X          = 1'b0;
   localparam logic        AXIS_Y          = 1'b1;
   localparam int unsigned STATUS_OP_X_BIT = 6720;
   localparam int unsigned STATUS_OP_Y_BIT = 6880;
   localparam int unsigned STATUS_CS_X_BIT = 6733;
   localparam int unsigned STATUS_CS_Y_BIT = 6893;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT_DROP} pwm_state_t;
endpackage
`default_nettype wire

// file: core/ms_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ms_tick_if;
   logic run;
   logic tick;
   modport source (input run, output tick);
   modport sink   (output run, input tick);
endinterface
`default_nettype wire

// file: core/ms_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen
   import axis_pwm_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      resetn,
   ms_tick_if.source      tb
);
   logic [TICK_W-1:0] count;
   wire               wrap = (count == TICK_W'(TICK_CYCLES - 1));

   // The divider restarts with each run so the first millisecond is full length.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         count   <= '0;
         tb.tick <= 1'b0;
      end else begin
         tb.tick <= tb.run && wrap;
         if (!tb.run || wrap) begin
            count <= '0;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: core/axis_pwm_output.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - period 1 to 20000 ms, repeated while requested
// - off duty 1 to 100 percent
// - output on selected axis X or Y
// - pulse only while request stays asserted
// - stop and emergency stop ignored while running
// - current address frozen, pulses not counted
// - set operating and constant-speed status bits
// - refuse start if axis busy or errored
// - other positioning commands ignored while running
// - travel limits not checked while running
// - period latched at start, later changes ignored
module axis_pwm_output
   import axis_pwm_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        pwm_request_contact,
   input  wire logic        axis_select,
   input  wire logic [15:0] period_ms_operand,
   input  wire logic [15:0] duty_pct_operand,
   input  wire logic        axis_x_busy,
   input  wire logic        axis_y_busy,
   input  wire logic        axis_x_error,
   input  wire logic        axis_y_error,
   input  wire logic        decel_stop_command,
   input  wire logic        emergency_stop_command,
   input  wire logic        other_command,
   input  wire logic        upper_limit,
   input  wire logic        lower_limit,
   output logic             pwm_out_x,
   output logic             pwm_out_y,
   output logic             operating_x,
   output logic             operating_y,
   output logic             const_speed_x,
   output logic             const_speed_y,
   output logic             start_refused,
   output logic             operand_error,
   output logic             pass_stop,
   output logic             pass_command,
   output logic             limit_check_enable,
   output logic             address_count_enable
);
   pwm_state_t  state;
   pwm_state_t  next_state;
   logic        axis;
   logic [15:0] period_ms;
   logic [15:0] off_ms;
   logic [15:0] ms_count;
   logic        wave;
   ms_tick_if   tb ();

   function automatic logic [15:0] off_time(input logic [15:0] per, input logic [15:0] duty);
      logic [31:0] prod;
      prod     = 32'(per) * 32'(duty);
      off_time = 16'(prod / 32'd100);
   endfunction

   // Both operands share one inclusive range test so their limits cannot drift apart.
   function automatic logic in_range(input logic [15:0] value, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (value >= lo) && (value <= hi);
   endfunction

   wire x_fault      = axis_x_busy | axis_x_error;
   wire y_fault      = axis_y_busy | axis_y_error;
   wire sel_busy     = (axis_select == AXIS_Y) ? y_fault : x_fault;
   wire period_ok    = in_range(period_ms_operand, PERIOD_MS_MIN, PERIOD_MS_MAX);
   wire duty_ok      = in_range(duty_pct_operand, DUTY_PCT_MIN, DUTY_PCT_MAX);
   wire running      = (state == ST_RUN);
   wire idle_request = (state == ST_IDLE) && pwm_request_contact;
   wire start_ok     = pwm_request_contact && !sel_busy && period_ok && duty_ok;
   wire start_run    = idle_request && start_ok;
   wire on_x         = running && (axis == AXIS_X);
   wire on_y         = running && (axis == AXIS_Y);

   // The last millisecond tick of a period closes it; the off phase then starts again.
   wire period_end   = tb.tick && (ms_count == period_ms - 16'h0001);
   wire off_done     = (ms_count >= off_ms);
   wire cut_edge     = period_end && (off_ms != 16'h0000);
   wire next_wave    = running && off_done && !cut_edge;

   assign tb.run = running;

   ms_tick_gen u_tick (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .tb      (tb)
   );

   // A refused request waits for the contact to drop, so a busy axis that frees up
   // mid-request does not start output unexpectedly.
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (pwm_request_contact) begin
               next_state = start_ok ? ST_RUN : ST_WAIT_DROP;
            end
         end
         ST_RUN: begin
            if (!pwm_request_contact) begin
               next_state = ST_IDLE;
            end
         end
         ST_WAIT_DROP: begin
            if (!pwm_request_contact) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         axis <= AXIS_X;
      end else if (start_run) begin
         axis <= axis_select;
      end
   end

   // Operand changes while running are ignored because the period is only sampled here.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         period_ms <= PERIOD_MS_MIN;
      end else if (start_run) begin
         period_ms <= period_ms_operand;
      end
   end

   // Off time is whole milliseconds, truncated; a short period with a small duty has no off phase.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         off_ms <= '0;
      end else if (start_run) begin
         off_ms <= off_time(period_ms_operand, duty_pct_operand);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ms_count <= '0;
      end else if (!running || period_end) begin
         ms_count <= '0;
      end else if (tb.tick) begin
         ms_count <= ms_count + 16'h0001;
      end
   end

   // Output is off for the first off_ms milliseconds of each period, on after.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wave <= 1'b0;
      end else begin
         wave <= next_wave;
      end
   end

   // Refusal flags keep the outcome of the last request taken in idle, until the next one.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         start_refused <= 1'b0;
      end else if (idle_request) begin
         start_refused <= sel_busy;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         operand_error <= 1'b0;
      end else if (idle_request) begin
         operand_error <= !(period_ok && duty_ok);
      end
   end

   assign pwm_out_x     = wave && on_x;
   assign pwm_out_y     = wave && on_y;
   assign operating_x   = on_x;
   assign operating_y   = on_y;
   assign const_speed_x = operating_x;
   assign const_speed_y = operating_y;

   // The positioning core sees these gates; stop inputs are simply masked while running.
   assign pass_stop            = !running && (decel_stop_command | emergency_stop_command);
   assign pass_command         = !running && other_command;
   assign limit_check_enable   = !running && (upper_limit | lower_limit | 1'b1);
   assign address_count_enable = !running;
endmodule
`default_nettype wire

// file: bench/axis_pwm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module axis_pwm_checker (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic pwm_request_contact,
   input wire logic operating_x,
   input wire logic operating_y,
   input wire logic const_speed_x,
   input wire logic const_speed_y,
   input wire logic pwm_out_x,
   input wire logic pwm_out_y,
   input wire logic pass_stop,
   input wire logic pass_command,
   input wire logic limit_check_enable,
   input wire logic address_count_enable
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire logic run = operating_x | operating_y;
   property p_start; $rose(operating_x) |-> $past(pwm_request_contact); endproperty
   a_start: assert property (p_start) else $error("run without request");
   property p_drop; !pwm_request_contact |=> !run; endproperty
   a_drop: assert property (p_drop) else $error("run after drop");
   property p_cs; {const_speed_x, const_speed_y} == {operating_x, operating_y}; endproperty
   a_cs: assert property (p_cs) else $error("status bits differ");
   property p_stop; run |-> !pass_stop; endproperty
   a_stop: assert property (p_stop) else $error("stop passed");
   property p_cmd; run |-> !pass_command; endproperty
   a_cmd: assert property (p_cmd) else $error("command passed");
   property p_lim; limit_check_enable != run; endproperty
   a_lim: assert property (p_lim) else $error("limit check wrong");
   property p_addr; address_count_enable != run; endproperty
   a_addr: assert property (p_addr) else $error("address counted");
   property p_axis; (pwm_out_x |-> operating_x) and (pwm_out_y |-> operating_y); endproperty
   a_axis: assert property (p_axis) else $error("wrong axis output");
endmodule
`default_nettype wire

// file: bench/pwm_requester.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_requester (
   input  wire logic        ref_clk,
   output logic             pwm_request_contact,
   output logic             axis_select,
   output logic [15:0]      period_ms_operand,
   output logic [15:0]      duty_pct_operand
);
   initial begin
      {pwm_request_contact, axis_select} = 2'h0;
      {period_ms_operand, duty_pct_operand} = {16'h0001, 16'h0001};
   end
   // Waiting an edge first keeps the request low for a cycle between runs.
   task automatic go(input logic a, input logic [15:0] p, input logic [15:0] d);
      @(posedge ref_clk) #2;
      {axis_select, period_ms_operand, duty_pct_operand} = {a, p, d};
      pwm_request_contact = 1'b1;
   endtask
   // Changes the period operand while a run is under way; the running period must not follow.
   task automatic retune(input logic [15:0] p);
      @(posedge ref_clk) #2;
      period_ms_operand = p;
   endtask
   // Dropping the request ends the waveform; reset is the only other way.
   task automatic halt();
      @(posedge ref_clk) #2;
      pwm_request_contact = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: bench/axis_pwm_output_tb.sv
`timescale 1ns/1ps
`default_nettype none
module axis_pwm_output_tb;
   typedef struct packed {logic ax; logic [15:0] per; logic [3:0] flt; logic ox; logic oy; logic rf; logic oe;} row_t;
   logic ref_clk = 1'b0;
   logic resetn, axis_x_busy, axis_y_busy, axis_x_error, axis_y_error;
   logic decel_stop_command, emergency_stop_command, other_command, upper_limit, lower_limit;
   wire logic pwm_request_contact, axis_select;
   wire logic [15:0] period_ms_operand, duty_pct_operand;
   wire logic pwm_out_x, pwm_out_y, operating_x, operating_y, const_speed_x, const_speed_y, start_refused;
   wire logic operand_error, pass_stop, pass_command, limit_check_enable, address_count_enable;
   int n_mismatch = 0;
   int checked = 0;
   row_t rows [7] = '{'{1'b0, 16'h0001, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0}, '{1'b1, 16'h4e20, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{1'b0, 16'h000a, 4'h8, 1'b0, 1'b0, 1'b1, 1'b0}, '{1'b0, 16'h000a, 4'h2, 1'b0, 1'b0, 1'b1, 1'b0},
      '{1'b1, 16'h000a, 4'h4, 1'b0, 1'b0, 1'b1, 1'b0}, '{1'b1, 16'h000a, 4'h1, 1'b0, 1'b0, 1'b1, 1'b0},
      '{1'b0, 16'h4e21, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1}};
   axis_pwm_output dut_u (.*);
   pwm_requester rq (.*);
   always #12.5 ref_clk = ~ref_clk;
   task automatic chk(input logic s, input logic e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %b expected %b", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   // An out-of-range operand must be flagged and must not start output.
   task automatic bad(input logic [15:0] p, input logic [15:0] d);
      rq.go(1'b0, p, d);
      cyc(2);
      chk(operand_error, 1'b1);
      chk(operating_x, 1'b0);
      rq.halt();
      cyc(1);
   endtask
   task automatic results();
      if (n_mismatch == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #2500000;
      n_mismatch++;
      results();
   end
   initial begin
      {resetn, axis_x_busy, axis_y_busy, axis_x_error, axis_y_error} = 5'h00;
      // Stop, command and limit inputs stay active so any leak past the mask shows.
      {decel_stop_command, emergency_stop_command, other_command, upper_limit, lower_limit} = 5'h1f;
      cyc(4);
      chk(limit_check_enable, 1'b1);
      chk(address_count_enable, 1'b1);
      resetn = 1'b1;
      foreach (rows[i]) begin
         {axis_x_busy, axis_y_busy, axis_x_error, axis_y_error} = rows[i].flt;
         rq.go(rows[i].ax, rows[i].per, 16'h0032);
         cyc(2);
         chk(operating_x, rows[i].ox);
         chk(operating_y, rows[i].oy);
         chk(const_speed_y, rows[i].oy);
         chk(start_refused, rows[i].rf);
         chk(operand_error, rows[i].oe);
         chk(pass_stop, !(rows[i].ox | rows[i].oy));
         chk(pass_command, !(rows[i].ox | rows[i].oy));
         chk(limit_check_enable, !(rows[i].ox | rows[i].oy));
         rq.halt();
         cyc(1);
         chk(operating_x | operating_y, 1'b0);
      end
      {axis_x_busy, axis_y_busy, axis_x_error, axis_y_error} = 4'h0;
      bad(16'h0000, 16'h0032);
      bad(16'h000a, 16'h0000);
      bad(16'h000a, 16'h0065);
      // One percent of one millisecond truncates to no off phase, so the output is on at once.
      rq.go(1'b1, 16'h0001, 16'h0001);
      cyc(2);
      chk(pwm_out_y, 1'b1);
      chk(pwm_out_x, 1'b0);
      chk(const_speed_y, 1'b1);
      chk(const_speed_x, 1'b0);
      rq.halt();
      cyc(1);
      chk(pwm_out_y, 1'b0);
      rq.go(1'b0, 16'h0002, 16'h0032);
      rq.retune(16'h0001);
      cyc(20000);
      chk(pwm_out_x, 1'b0);
      cyc(40000);
      chk(pwm_out_x, 1'b1);
      chk(pwm_out_y, 1'b0);
      chk(address_count_enable, 1'b0);
      cyc(20000);
      chk(pwm_out_x, 1'b1);
      cyc(1);
      chk(pwm_out_x, 1'b0);
      resetn = 1'b0;
      cyc(1);
      chk(operating_x, 1'b0);
      chk(pwm_out_x, 1'b0);
      chk(limit_check_enable, 1'b1);
      rq.halt();
      resetn = 1'b1;
      cyc(2);
      chk(operating_x, 1'b0);
      rq.go(1'b0, 16'h0001, 16'h0001);
      cyc(2);
      chk(pwm_out_x, 1'b1);
      rq.halt();
      cyc(1);
      chk(operating_x, 1'b0);
      results();
   end
endmodule
bind axis_pwm_output axis_pwm_checker chk_u (.*);
`default_nettype wire
